// [logic/rmctl_pkg.sv]
// Constants and types shared by the receiver mode control block.
// Assumes a 50 MHz core clock and a 32-bit APB register port.
package rmctl_pkg;
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned WORD_W = 10;
    localparam int unsigned FEAT_W = 4;
    localparam int unsigned PIN_W = 6;
    // Register byte offsets
    localparam logic [11:0] CTRL_OFF = 12'h000;
    localparam logic [11:0] STATUS_OFF = 12'h004;
    // Control register fields and reset value
    localparam int unsigned CTRL_FEAT_LSB = 0;
    localparam logic [3:0] CTRL_FEAT_RST = 4'h0;
    // Status register field positions
    localparam int unsigned ST_LOCKED = 0;
    localparam int unsigned ST_VIDEO = 1;
    localparam int unsigned ST_ASYNC = 2;
    localparam int unsigned ST_THROUGH = 3;
    localparam int unsigned ST_AUTO = 4;
    localparam int unsigned ST_FLYWHEEL = 5;
    localparam int unsigned ST_BUFFER = 6;
    localparam int unsigned ST_HUNT = 7;
    // Synchroniser depth for non-synchronous pins
    localparam int unsigned SYNC_STAGES = 2;

    typedef enum logic [1:0] {
        MODE_HUNT,
        MODE_VIDEO,
        MODE_ASYNC,
        MODE_THROUGH
    } rmctl_mode_type;

    // Non-synchronous pins, in synchroniser order
    typedef struct packed {
        logic rd_clock;
        logic buffer_enable;
        logic flywheel_enable;
        logic async_iface_select;
        logic video_path_select;
        logic detect_select;
    } rmctl_pins_type;
endpackage

// [logic/rmctl_sync.sv]
// Two-stage synchroniser, one chain per bit.
// Assumes inputs are asynchronous to CLK; only the second stage is used outside.
`timescale 1ns/10ps
`default_nettype none
module rmctl_sync #(
    parameter int unsigned WIDTH = 6
) (
    input wire logic CLK,              // Core clock
    input wire logic RST,              // Asynchronous reset, active high
    input wire logic [WIDTH-1:0] d_in, // Raw pin levels
    output logic [WIDTH-1:0] d_out     // Synchronised levels
);
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1)
        begin : g_bit
            logic stage1_ff;
            logic stage2_ff;
            always_ff @(posedge CLK or posedge RST)
            begin
                if (RST)
                begin
                    stage1_ff <= 1'b0;
                    stage2_ff <= 1'b0;
                end
                else
                begin
                    stage1_ff <= d_in[i];
                    stage2_ff <= stage1_ff;
                end
            end
            assign d_out[i] = stage2_ff;
        end
    endgenerate
endmodule
`default_nettype wire

// [logic/rmctl_top.sv]
// Receiver mode control: auto/manual path selection, mode pins, flywheel
// enable and output-path select, with an APB register port.
// Assumes lock and data inputs come from datapath logic on CLK.
`timescale 1ns/10ps
`default_nettype none
module rmctl_top #(
    parameter int unsigned WORD_W = rmctl_pkg::WORD_W,
    parameter int unsigned FEAT_W = rmctl_pkg::FEAT_W
) (
    input wire logic CLK,                        // Recovered pixel clock
    input wire logic RST,                        // Asynchronous reset, active high
    input wire logic PSEL,                       // APB select
    input wire logic PENABLE,                    // APB enable
    input wire logic PWRITE,                     // APB write
    input wire logic [11:0] PADDR,               // APB byte address
    input wire logic [31:0] PWDATA,              // APB write data
    output logic [31:0] PRDATA,                  // APB read data
    output logic PREADY,                         // APB ready
    output logic PSLVERR,                        // APB error on unmapped address
    input wire logic DETECT_SELECT,              // Auto (high) / manual (low) pin
    input wire logic VIDEO_PATH_SELECT_I,        // Video path pin, input side
    output logic VIDEO_PATH_SELECT_O,            // Video path pin, driven level
    output logic VIDEO_PATH_SELECT_OE,           // Video path pin, drive enable
    input wire logic ASYNC_IFACE_SELECT_I,       // Async interface pin, input side
    output logic ASYNC_IFACE_SELECT_O,           // Async interface pin, driven level
    output logic ASYNC_IFACE_SELECT_OE,          // Async interface pin, drive enable
    input wire logic FLYWHEEL_ENABLE,            // Flywheel enable pin
    input wire logic BUFFER_ENABLE,              // Line buffer enable pin
    input wire logic RD_CLOCK,                   // External buffer read clock pin
    input wire logic VIDEO_LOCK,                 // Datapath locked to video stream
    input wire logic ASYNC_LOCK,                 // Datapath locked to async stream
    input wire logic RECLOCK_LOCK,               // Reclocker locked
    input wire logic [WORD_W-1:0] DATA_IN,       // Deserialised word
    input wire logic [WORD_W-1:0] BUF_DATA,      // Word at line buffer head
    output logic BUF_READ,                       // Pop line buffer, one-cycle pulse
    output logic [WORD_W-1:0] DOUT,              // Parallel output word
    output logic LOCKED,                         // Lock indicator
    output logic VIDEO_DECODE_EN,                // Descramble, decode, word align
    output logic ASYNC_DECODE_EN,                // Async align and decode
    output logic [FEAT_W-1:0] FEATURE_EN,        // Processing features
    output logic FLYWHEEL_RUN,                   // Flywheel running
    output logic TIMING_ERR_EN,                  // Timing-based reference checks
    output logic DETECT_HUNT,                    // Automatic stream detection active
    output logic BUFFER_PATH                     // Output leaves through the buffer
);
    rmctl_pkg::rmctl_pins_type pins_raw;
    rmctl_pkg::rmctl_pins_type pins_s;
    rmctl_pkg::rmctl_mode_type mode_ff;
    rmctl_pkg::rmctl_mode_type nxt_mode;
    logic locked_ff;
    logic nxt_locked;
    logic rd_prev_ff;
    logic rd_rise;
    logic buf_sel;
    logic [FEAT_W-1:0] feat_req_ff;
    logic [31:0] status_word;
    logic apb_setup;
    logic apb_done;
    logic addr_ok;

    assign pins_raw.detect_select = DETECT_SELECT;
    assign pins_raw.video_path_select = VIDEO_PATH_SELECT_I;
    assign pins_raw.async_iface_select = ASYNC_IFACE_SELECT_I;
    assign pins_raw.flywheel_enable = FLYWHEEL_ENABLE;
    assign pins_raw.buffer_enable = BUFFER_ENABLE;
    assign pins_raw.rd_clock = RD_CLOCK;

    rmctl_sync #(
        .WIDTH(rmctl_pkg::PIN_W)
    ) u_sync (
        .CLK(CLK),
        .RST(RST),
        .d_in(pins_raw),
        .d_out(pins_s)
    );

    // Mode choice from synchronised pins and datapath locks
    always_comb
    begin
        if (pins_s.detect_select)
        begin
            if (VIDEO_LOCK)
                nxt_mode = rmctl_pkg::MODE_VIDEO;
            else if (ASYNC_LOCK)
                nxt_mode = rmctl_pkg::MODE_ASYNC;
            else
                nxt_mode = rmctl_pkg::MODE_HUNT;
        end
        else if (pins_s.async_iface_select)
            nxt_mode = rmctl_pkg::MODE_ASYNC;
        else if (pins_s.video_path_select)
            nxt_mode = rmctl_pkg::MODE_VIDEO;
        else
            nxt_mode = rmctl_pkg::MODE_THROUGH;
    end

    always_comb
    begin
        case (nxt_mode)
            rmctl_pkg::MODE_VIDEO: nxt_locked = VIDEO_LOCK;
            rmctl_pkg::MODE_ASYNC: nxt_locked = ASYNC_LOCK;
            rmctl_pkg::MODE_THROUGH: nxt_locked = RECLOCK_LOCK;
            default: nxt_locked = 1'b0;
        endcase
    end

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            mode_ff <= rmctl_pkg::MODE_HUNT;
            locked_ff <= 1'b0;
        end
        else
        begin
            mode_ff <= nxt_mode;
            locked_ff <= nxt_locked;
        end
    end

    // Mode pins: driven status in auto, inputs in manual
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            VIDEO_PATH_SELECT_OE <= 1'b0;
            ASYNC_IFACE_SELECT_OE <= 1'b0;
            VIDEO_PATH_SELECT_O <= 1'b0;
            ASYNC_IFACE_SELECT_O <= 1'b0;
            DETECT_HUNT <= 1'b0;
        end
        else
        begin
            VIDEO_PATH_SELECT_OE <= pins_s.detect_select;
            ASYNC_IFACE_SELECT_OE <= pins_s.detect_select;
            VIDEO_PATH_SELECT_O <= pins_s.detect_select && mode_ff == rmctl_pkg::MODE_VIDEO && locked_ff;
            ASYNC_IFACE_SELECT_O <= pins_s.detect_select && mode_ff == rmctl_pkg::MODE_ASYNC && locked_ff;
            DETECT_HUNT <= pins_s.detect_select && mode_ff == rmctl_pkg::MODE_HUNT;
        end
    end

    // Datapath enables; all gated by lock
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            LOCKED <= 1'b0;
            VIDEO_DECODE_EN <= 1'b0;
            ASYNC_DECODE_EN <= 1'b0;
            FEATURE_EN <= '0;
        end
        else
        begin
            LOCKED <= locked_ff;
            VIDEO_DECODE_EN <= mode_ff == rmctl_pkg::MODE_VIDEO && locked_ff;
            ASYNC_DECODE_EN <= mode_ff == rmctl_pkg::MODE_ASYNC && locked_ff;
            if (mode_ff == rmctl_pkg::MODE_VIDEO && locked_ff)
                FEATURE_EN <= feat_req_ff;
            else
                FEATURE_EN <= '0;
        end
    end

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            FLYWHEEL_RUN <= 1'b0;
            TIMING_ERR_EN <= 1'b0;
        end
        else
        begin
            FLYWHEEL_RUN <= pins_s.flywheel_enable && mode_ff == rmctl_pkg::MODE_VIDEO;
            TIMING_ERR_EN <= pins_s.flywheel_enable && mode_ff == rmctl_pkg::MODE_VIDEO && locked_ff;
        end
    end

    // Output path: buffer on rising read-clock edges, else every pixel clock
    assign buf_sel = pins_s.buffer_enable
        && (mode_ff == rmctl_pkg::MODE_VIDEO || mode_ff == rmctl_pkg::MODE_ASYNC);
    assign rd_rise = pins_s.rd_clock && !rd_prev_ff;

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            rd_prev_ff <= 1'b0;
        else
            rd_prev_ff <= pins_s.rd_clock;
    end

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            DOUT <= '0;
            BUF_READ <= 1'b0;
            BUFFER_PATH <= 1'b0;
        end
        else
        begin
            BUFFER_PATH <= buf_sel && locked_ff;
            BUF_READ <= buf_sel && locked_ff && rd_rise;
            if (!locked_ff)
                DOUT <= '0;
            else if (!buf_sel)
                DOUT <= DATA_IN;
            else if (rd_rise)
                DOUT <= BUF_DATA;
        end
    end

    // APB slave: ready in the first access cycle, no wait states
    assign apb_setup = PSEL && !PENABLE;
    assign apb_done = PSEL && PENABLE && PREADY;
    assign addr_ok = PADDR == rmctl_pkg::CTRL_OFF || PADDR == rmctl_pkg::STATUS_OFF;

    always_comb
    begin
        status_word = '0;
        status_word[rmctl_pkg::ST_LOCKED] = locked_ff;
        status_word[rmctl_pkg::ST_VIDEO] = mode_ff == rmctl_pkg::MODE_VIDEO;
        status_word[rmctl_pkg::ST_ASYNC] = mode_ff == rmctl_pkg::MODE_ASYNC;
        status_word[rmctl_pkg::ST_THROUGH] = mode_ff == rmctl_pkg::MODE_THROUGH;
        status_word[rmctl_pkg::ST_AUTO] = pins_s.detect_select;
        status_word[rmctl_pkg::ST_FLYWHEEL] = pins_s.flywheel_enable;
        status_word[rmctl_pkg::ST_BUFFER] = buf_sel;
        status_word[rmctl_pkg::ST_HUNT] = mode_ff == rmctl_pkg::MODE_HUNT;
    end

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA <= '0;
        end
        else
        begin
            PREADY <= apb_setup;
            PSLVERR <= apb_setup && !addr_ok;
            if (apb_setup && !PWRITE && PADDR == rmctl_pkg::CTRL_OFF)
                PRDATA <= {{(32 - FEAT_W){1'b0}}, feat_req_ff};
            else if (apb_setup && !PWRITE && PADDR == rmctl_pkg::STATUS_OFF)
                PRDATA <= status_word;
            else if (apb_setup)
                PRDATA <= '0;
        end
    end

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            feat_req_ff <= FEAT_W'(rmctl_pkg::CTRL_FEAT_RST);
        else if (apb_done && PWRITE && PADDR == rmctl_pkg::CTRL_OFF)
            feat_req_ff <= PWDATA[rmctl_pkg::CTRL_FEAT_LSB +: FEAT_W];
    end

    // Checks
    sequence s_auto_video_lock;
        pins_s.detect_select && mode_ff == rmctl_pkg::MODE_VIDEO && locked_ff;
    endsequence

    sequence s_pin_high;
        VIDEO_PATH_SELECT_O;
    endsequence

    a_video_status_high: assert property (@(posedge CLK) disable iff (RST)
        s_auto_video_lock |=> s_pin_high)
        else $error("Video status not raised while video locked");

    a_video_status_low: assert property (@(posedge CLK) disable iff (RST)
        (mode_ff != rmctl_pkg::MODE_VIDEO || !locked_ff) |=> !VIDEO_PATH_SELECT_O)
        else $error("Video status high without video lock");

    a_async_status: assert property (@(posedge CLK) disable iff (RST)
        ASYNC_IFACE_SELECT_O |-> $past(mode_ff) == rmctl_pkg::MODE_ASYNC && $past(locked_ff))
        else $error("Async status high without async lock");

    a_features_gated: assert property (@(posedge CLK) disable iff (RST)
        (FEATURE_EN != '0) |-> $past(mode_ff) == rmctl_pkg::MODE_VIDEO && $past(locked_ff))
        else $error("Features enabled outside locked video mode");

    a_manual_video_feat: assert property (@(posedge CLK) disable iff (RST)
        (mode_ff == rmctl_pkg::MODE_VIDEO && locked_ff && !pins_s.detect_select) |=>
        FEATURE_EN == $past(feat_req_ff))
        else $error("Requested features not granted in manual video mode");

    a_pins_direction: assert property (@(posedge CLK) disable iff (RST)
        $changed(pins_s.detect_select) |=> VIDEO_PATH_SELECT_OE == $past(pins_s.detect_select)
        && ASYNC_IFACE_SELECT_OE == $past(pins_s.detect_select))
        else $error("Mode pin direction not following select");

    a_manual_async_wins: assert property (@(posedge CLK) disable iff (RST)
        (!pins_s.detect_select && pins_s.async_iface_select) |=> mode_ff == rmctl_pkg::MODE_ASYNC)
        else $error("Manual async selection not taken");

    a_manual_video_sel: assert property (@(posedge CLK) disable iff (RST)
        (!pins_s.detect_select && !pins_s.async_iface_select && pins_s.video_path_select)
        |=> mode_ff == rmctl_pkg::MODE_VIDEO)
        else $error("Manual video selection not taken");

    a_video_decode_gate: assert property (@(posedge CLK) disable iff (RST)
        VIDEO_DECODE_EN |-> $past(mode_ff) == rmctl_pkg::MODE_VIDEO && $past(locked_ff))
        else $error("Video decode enabled outside locked video mode");

    a_manual_pins_in: assert property (@(posedge CLK) disable iff (RST)
        !pins_s.detect_select |=> !VIDEO_PATH_SELECT_OE && !ASYNC_IFACE_SELECT_OE)
        else $error("Mode pins driven in manual mode");

    a_manual_through: assert property (@(posedge CLK) disable iff (RST)
        (!pins_s.detect_select && !pins_s.async_iface_select && !pins_s.video_path_select)
        |=> mode_ff == rmctl_pkg::MODE_THROUGH)
        else $error("Manual data-through mode not taken");

    a_timing_err_off: assert property (@(posedge CLK) disable iff (RST)
        !pins_s.flywheel_enable |=> !TIMING_ERR_EN && !FLYWHEEL_RUN)
        else $error("Timing checks on with flywheel disabled");

    a_unlock_forces_low: assert property (@(posedge CLK) disable iff (RST)
        !locked_ff |=> DOUT == '0 && !VIDEO_DECODE_EN && !ASYNC_DECODE_EN && !BUF_READ)
        else $error("Outputs not forced low while unlocked");

    a_bypass_data: assert property (@(posedge CLK) disable iff (RST)
        (locked_ff && !buf_sel) |=> DOUT == $past(DATA_IN))
        else $error("Bypass path not passing pixel data");

    a_buffer_word: assert property (@(posedge CLK) disable iff (RST)
        (locked_ff && buf_sel && !rd_rise) |=> $stable(DOUT) && !BUF_READ)
        else $error("Buffer output changed without read clock edge");
endmodule
`default_nettype wire

// [verification/rmctl_app.sv]
// Application-side model: owns the mode pins in manual mode, makes the read clock.
// Assumes the device raises its drive enables only while it owns a pin.
`timescale 1ns/10ps
`default_nettype none
module rmctl_app (
    input wire logic clk,        // Core clock
    input wire logic drive_en,   // Application may drive the mode pins
    input wire logic video_want, // Level asked on the video pin
    input wire logic async_want, // Level asked on the async pin
    input wire logic rd_run,     // Read clock bursts
    input wire logic video_o,    // Device level, video pin
    input wire logic video_oe,   // Device drives video pin
    input wire logic async_o,    // Device level, async pin
    input wire logic async_oe,   // Device drives async pin
    output logic video_pin,      // Resolved video pin
    output logic async_pin,      // Resolved async pin
    output var logic rd_clock    // Buffer read clock
);
    logic video_last_ff;
    logic async_last_ff;
    logic phase_ff = 1'h0;
    // Device wins; a pin nobody drives shows the inverse of its last driven level
    always_comb video_pin = video_oe ? video_o : (drive_en ? video_want : ~video_last_ff);
    always_comb async_pin = async_oe ? async_o : (drive_en ? async_want : ~async_last_ff);
    always_ff @(posedge clk)
    begin
        if (video_oe || drive_en)
            video_last_ff <= video_pin;
        if (async_oe || drive_en)
            async_last_ff <= async_pin;
    end
    // Read clock stands low outside bursts, period of four core cycles
    always_ff @(posedge clk)
    begin
        phase_ff <= rd_run & ~phase_ff;
        if (!rd_run)
            rd_clock <= 1'h0;
        else if (phase_ff)
            rd_clock <= ~rd_clock;
    end
endmodule
`default_nettype wire

// [verification/tb_rmctl_top.sv]
// Self-checking bench for the receiver mode control block.
// Assumes rmctl_top with default parameters and the rmctl_app pin model.
`timescale 1ns/10ps
`default_nettype none
module tb_rmctl_top;
    logic CLK, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, err;
    logic [11:0] PADDR;
    logic [31:0] PWDATA, PRDATA, rd;
    logic det, drv, vw, aw, fw, be, vlk, alk, rlk, rd_run, rdclk, rd_q;
    logic vpin, apin, vo, voe, ao, aoe, bread, lk, vde, ade, fwr, tee, hunt, bpath;
    logic [9:0] din, bdat, dout;
    logic [3:0] feat;
    int n_mismatch, cmp_count, cyc, n_pop, n_rise, p0, r0;

    rmctl_top uut (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
        .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
        .DETECT_SELECT(det), .VIDEO_PATH_SELECT_I(vpin), .VIDEO_PATH_SELECT_O(vo),
        .VIDEO_PATH_SELECT_OE(voe), .ASYNC_IFACE_SELECT_I(apin), .ASYNC_IFACE_SELECT_O(ao),
        .ASYNC_IFACE_SELECT_OE(aoe), .FLYWHEEL_ENABLE(fw), .BUFFER_ENABLE(be), .RD_CLOCK(rdclk),
        .VIDEO_LOCK(vlk), .ASYNC_LOCK(alk), .RECLOCK_LOCK(rlk), .DATA_IN(din), .BUF_DATA(bdat),
        .BUF_READ(bread), .DOUT(dout), .LOCKED(lk), .VIDEO_DECODE_EN(vde), .ASYNC_DECODE_EN(ade),
        .FEATURE_EN(feat), .FLYWHEEL_RUN(fwr), .TIMING_ERR_EN(tee), .DETECT_HUNT(hunt),
        .BUFFER_PATH(bpath));

    rmctl_app app (.clk(CLK), .drive_en(drv), .video_want(vw), .async_want(aw), .rd_run(rd_run),
        .video_o(vo), .video_oe(voe), .async_o(ao), .async_oe(aoe), .video_pin(vpin),
        .async_pin(apin), .rd_clock(rdclk));

    initial
    begin
        CLK = 1'h0;
        forever #10 CLK = ~CLK;
    end

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer; entered just after a rising edge, leaves one idle cycle
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        PSEL <= 1'h1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= wd;
        @(posedge CLK);
        PENABLE <= 1'h1;
        do
        begin
            @(posedge CLK);
        end
        while (PREADY !== 1'h1);
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 1'h0;
        PENABLE <= 1'h0;
        @(posedge CLK);
    endtask

    task automatic pins(input logic d, v, a, w, b, vl, al, rl);
        det <= d;
        drv <= ~d;
        vw <= v;
        aw <= a;
        fw <= w;
        be <= b;
        vlk <= vl;
        alk <= al;
        rlk <= rl;
        repeat (6) @(posedge CLK);
    endtask

    function automatic logic [31:0] mk(input logic l, v, a, input logic [3:0] f, input logic w, t, h, b);
        return 32'({l, v, a, f, w, t, h, b});
    endfunction

    function automatic logic [31:0] outs();
        return mk(lk, vde, ade, feat, fwr, tee, hunt, bpath);
    endfunction

    always @(posedge CLK)
    begin
        rd_q <= rdclk;
        if (bread === 1'h1)
            n_pop++;
        if (rdclk === 1'h1 && rd_q === 1'h0)
            n_rise++;
        cyc++;
        if (cyc == 3000)
        begin
            n_mismatch++;
            stop_test();
        end
    end

    initial
    begin
        {PSEL, PENABLE, PWRITE, PADDR, PWDATA, det, vw, aw, fw, be, vlk, alk, rlk, rd_run} = '0;
        drv = 1'h1;
        RST = 1'h1;
        din = 10'h15a;
        bdat = 10'h000;
        repeat (6) @(posedge CLK);
        RST <= 1'h0;
        @(posedge CLK);
        chk(outs(), 32'h0);
        chk({voe, aoe, bread, dout}, 32'h0);
        apb(1'h1, 12'h000, 32'hffffffff);
        apb(1'h0, 12'h000, 32'h0);
        chk(rd, 32'h0000000f);
        apb(1'h1, 12'h004, 32'hffffffff);
        chk(err, 32'h0);
        apb(1'h0, 12'h010, 32'h0);
        chk(err, 32'h1);
        chk(rd, 32'h0);
        pins(1'h0, 1'h1, 1'h0, 1'h1, 1'h0, 1'h1, 1'h0, 1'h0);
        chk(outs(), mk(1'h1, 1'h1, 1'h0, 4'hf, 1'h1, 1'h1, 1'h0, 1'h0));
        chk({voe, aoe}, 32'h0);
        chk(dout, din);
        apb(1'h0, 12'h004, 32'h0);
        chk(rd, 32'h00000023);
        fw <= 1'h0;
        repeat (2) @(posedge CLK);
        chk(fwr, 32'h1);
        repeat (4) @(posedge CLK);
        chk(outs(), mk(1'h1, 1'h1, 1'h0, 4'hf, 1'h0, 1'h0, 1'h0, 1'h0));
        pins(1'h0, 1'h1, 1'h0, 1'h0, 1'h1, 1'h1, 1'h0, 1'h0);
        chk(bpath, 32'h1);
        bdat <= 10'h2a5;
        p0 = n_pop;
        r0 = n_rise;
        rd_run <= 1'h1;
        repeat (16) @(posedge CLK);
        rd_run <= 1'h0;
        repeat (6) @(posedge CLK);
        chk(dout, 10'h2a5);
        chk(n_pop - p0, n_rise - r0);
        pins(1'h0, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0);
        chk({lk, vde, feat, dout}, 32'h0);
        pins(1'h0, 1'h1, 1'h1, 1'h0, 1'h0, 1'h1, 1'h1, 1'h0);
        chk(outs(), mk(1'h1, 1'h0, 1'h1, 4'h0, 1'h0, 1'h0, 1'h0, 1'h0));
        pins(1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1);
        chk(outs(), mk(1'h1, 1'h0, 1'h0, 4'h0, 1'h0, 1'h0, 1'h0, 1'h0));
        chk(dout, din);
        pins(1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0);
        chk({voe, aoe, vo, ao, vpin}, 32'h1d);
        chk(outs(), mk(1'h1, 1'h1, 1'h0, 4'hf, 1'h0, 1'h0, 1'h0, 1'h0));
        apb(1'h0, 12'h004, 32'h0);
        chk(rd, 32'h00000013);
        pins(1'h1, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0);
        chk({voe, aoe, vo, ao}, 32'hd);
        chk(outs(), mk(1'h1, 1'h0, 1'h1, 4'h0, 1'h0, 1'h0, 1'h0, 1'h0));
        pins(1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1);
        chk({voe, aoe, vo, ao}, 32'hc);
        chk(outs(), mk(1'h0, 1'h0, 1'h0, 4'h0, 1'h0, 1'h0, 1'h1, 1'h0));
        chk(dout, 32'h0);
        pins(1'h0, 1'h1, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0);
        chk({voe, aoe}, 32'h0);
        stop_test();
    end
endmodule
`default_nettype wire
